// *** hw/emu_bus_map.svh ***
// emu_bus_map.svh: register offsets, field positions, reset values and cycle counts
// assumes: included by bare name, byte addresses on a 32-bit Avalon-MM slave
`ifndef EMU_BUS_MAP_SVH
`define EMU_BUS_MAP_SVH

// register byte offsets
`define EMU_OFS_CONFIG 8'h00
`define EMU_OFS_ADDR 8'h04
`define EMU_OFS_WDATA 8'h08
`define EMU_OFS_CMD 8'h0C
`define EMU_OFS_RDATA 8'h10
`define EMU_OFS_STATUS 8'h14

// config register fields
`define EMU_CFG_INTERNAL_RAM_SELECT_BIT 0
`define EMU_CFG_INTERNAL_BOOT_SELECT_BIT 1
`define EMU_CFG_MFM_LSB 2
`define EMU_CFG_TOGGLE_BIT 4
`define EMU_CFG_TWO_CHIP_BIT 5
`define EMU_CFG_POWER_SAVE_BIT 6
`define EMU_CFG_ASYNC_BIT 7
`define EMU_CFG_CPU_SLOW_BIT 8
`define EMU_CFG_WIDTH 9
`define EMU_CFG_RESET 9'h000

// command register fields
`define EMU_CMD_GO_BIT 0
`define EMU_CMD_WRITE_BIT 1
`define EMU_CMD_CE1_BIT 2

// status register fields
`define EMU_ST_BUSY_BIT 0
`define EMU_ST_DONE_BIT 1
`define EMU_ST_ERR_BIT 2
`define EMU_ST_LOWPWR_BIT 3
`define EMU_ST_RAMSRC_LSB 4
`define EMU_ST_PINMODE_LSB 8
`define EMU_ST_CE1_LSB 12

// access cycle lengths in link clock cycles
`define EMU_FAST_CYCLES 4
`define EMU_SLOW_CYCLES 128
`define EMU_SLOW_CE_CYCLES 1

`endif

// *** hw/emu_bus_memory_select.sv ***
// emu_bus_memory_select: memory source decode, chip enables and external bus engine
// assumes: registers reached over Avalon-MM, link side on its own free running clock,
// the pad ring resolves data drive, weak keeper and the external bus wires
`timescale 1ns/10ps
`include "emu_bus_map.svh"

module emu_bus_memory_select #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 32
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_second_test_pin,
   output emu_bus_pkg::ram_source_t o_ram_source,
   output emu_bus_pkg::pin_mode_t o_pin_mode,
   output emu_bus_pkg::ce1_target_t o_ce1_target,
   input wire logic i_link_clk,
   output logic o_external_bus_clock_out,
   output logic o_program_mem_chip_enable_n,
   output logic o_data_boot_chip_enable_n,
   output logic o_write_enable_out_n,
   output logic [ADDR_W-1:0] o_mem_addr,
   output logic [DATA_W-1:0] o_mem_data,
   output logic o_mem_data_oe,
   input wire logic [DATA_W-1:0] i_mem_data,
   output logic o_data_hold_en,
   output logic [DATA_W-1:0] o_data_hold
);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   emu_bus_pkg::config_t cfg;
   logic [ADDR_W-1:0] acc_addr;
   logic [DATA_W-1:0] acc_wdata;
   emu_bus_pkg::access_cmd_t acc_cmd;
   logic [DATA_W-1:0] acc_rdata;
   logic busy;
   logic done;
   logic err;
   logic ack;
   logic req_toggle;
   logic test_pin_s1;
   logic test_pin_s2;
   logic done_s1;
   logic done_s2;
   logic done_s3;
   logic done_seen;
   logic low_power;
   logic [31:0] next_readdata;
   logic [31:0] wmask;
   logic wr_cfg;
   logic wr_cmd;
   logic go;
   logic go_ok;
   logic done_toggle;
   logic [DATA_W-1:0] link_rdata;

   assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign wr_cfg = i_avs_write && !ack && i_avs_address == `EMU_OFS_CONFIG;
   assign wr_cmd = i_avs_write && !ack && i_avs_address == `EMU_OFS_CMD;
   assign go = wr_cmd && i_avs_byteenable[0] && i_avs_writedata[`EMU_CMD_GO_BIT];
   // a second enable request is refused unless the two-chip flag is set and it reaches an external chip
   assign go_ok = !busy && (!i_avs_writedata[`EMU_CMD_CE1_BIT] ||
                  (cfg.two_chip_bus_flag && o_ce1_target != emu_bus_pkg::CE1_NONE));

   // one wait state on every access: the answer stands at the second edge
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         ack <= 1'b0;
      end else begin
         ack <= (i_avs_read || i_avs_write) && !ack;
      end
   end
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         cfg <= emu_bus_pkg::config_t'(`EMU_CFG_RESET);
      end else if (wr_cfg) begin
         cfg <= emu_bus_pkg::config_t'((cfg & ~wmask[`EMU_CFG_WIDTH-1:0]) |
                (i_avs_writedata[`EMU_CFG_WIDTH-1:0] & wmask[`EMU_CFG_WIDTH-1:0]));
      end
   end

   // address and write data are frozen while an access is in flight, so the
   // link side may read them directly once it has seen the request toggle
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         acc_addr <= '0;
         acc_wdata <= '0;
      end else if (i_avs_write && !ack && !busy) begin
         if (i_avs_address == `EMU_OFS_ADDR) begin
            acc_addr <= ADDR_W'((acc_addr & ~wmask[ADDR_W-1:0]) |
                        (i_avs_writedata[ADDR_W-1:0] & wmask[ADDR_W-1:0]));
         end
         if (i_avs_address == `EMU_OFS_WDATA) begin
            acc_wdata <= (acc_wdata & ~wmask[DATA_W-1:0]) |
                         (i_avs_writedata[DATA_W-1:0] & wmask[DATA_W-1:0]);
         end
      end
   end

   // ----------------------------------------------------------------
   // request and completion handshake
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
      end else begin
         done_s1 <= done_toggle;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
      end
   end
   assign done_seen = done_s2 ^ done_s3;

   // set wins over clear for done and err: a clear comes with a new go only
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         busy <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
         req_toggle <= 1'b0;
         acc_cmd <= '0;
         acc_rdata <= '0;
      end else begin
         if (go && go_ok) begin
            busy <= 1'b1;
            done <= 1'b0;
            err <= 1'b0;
            req_toggle <= ~req_toggle;
            acc_cmd.write <= i_avs_writedata[`EMU_CMD_WRITE_BIT];
            acc_cmd.use_ce1 <= i_avs_writedata[`EMU_CMD_CE1_BIT];
         end else if (go && !busy) begin
            err <= 1'b1;
         end
         if (done_seen) begin
            busy <= 1'b0;
            done <= 1'b1;
            acc_rdata <= link_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // source and pin decode
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         test_pin_s1 <= 1'b0;
         test_pin_s2 <= 1'b0;
      end else begin
         test_pin_s1 <= i_second_test_pin;
         test_pin_s2 <= test_pin_s1;
      end
   end

   always_comb begin
      if (cfg.internal_ram_select) begin
         o_ram_source = emu_bus_pkg::RAM_INTERNAL;
      end else if (cfg.multipin_mode_field == 2'h3) begin
         o_ram_source = emu_bus_pkg::RAM_EMU_BUS;
      end else begin
         o_ram_source = emu_bus_pkg::RAM_MULTIPIN_BUS;
      end
   end

   always_comb begin
      if (cfg.multipin_mode_field == 2'h3 || (cfg.test_toggle_bit && test_pin_s2)) begin
         o_pin_mode = emu_bus_pkg::PINS_PORT;
      end else begin
         o_pin_mode = emu_bus_pkg::pin_mode_t'(cfg.multipin_mode_field);
      end
   end

   always_comb begin
      if (!cfg.internal_ram_select) begin
         o_ce1_target = emu_bus_pkg::CE1_EXT_RAM;
      end else if (!cfg.internal_boot_select) begin
         o_ce1_target = emu_bus_pkg::CE1_EXT_BOOT;
      end else begin
         o_ce1_target = emu_bus_pkg::CE1_NONE;
      end
   end

   // fast and slow cpu modes both qualify
   assign low_power = !cfg.two_chip_bus_flag && cfg.power_saving_bus_flag &&
                      cfg.async_bus_flag;

   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (i_avs_address)
         `EMU_OFS_CONFIG: next_readdata[`EMU_CFG_WIDTH-1:0] = cfg;
         `EMU_OFS_ADDR: next_readdata[ADDR_W-1:0] = acc_addr;
         `EMU_OFS_WDATA: next_readdata[DATA_W-1:0] = acc_wdata;
         `EMU_OFS_CMD: next_readdata[2:1] = {acc_cmd.use_ce1, acc_cmd.write};
         `EMU_OFS_RDATA: next_readdata[DATA_W-1:0] = acc_rdata;
         `EMU_OFS_STATUS: begin
            next_readdata[`EMU_ST_BUSY_BIT] = busy;
            next_readdata[`EMU_ST_DONE_BIT] = done;
            next_readdata[`EMU_ST_ERR_BIT] = err;
            next_readdata[`EMU_ST_LOWPWR_BIT] = low_power;
            next_readdata[`EMU_ST_RAMSRC_LSB+:2] = o_ram_source;
            next_readdata[`EMU_ST_PINMODE_LSB+:2] = o_pin_mode;
            next_readdata[`EMU_ST_CE1_LSB+:2] = o_ce1_target;
         end
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_avs_readdata <= 32'h0000_0000;
      end else if (i_avs_read && !ack) begin
         o_avs_readdata <= next_readdata;
      end
   end

   // ----------------------------------------------------------------
   // link domain: bus clock, strobes and data
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {LINK_IDLE, LINK_ACCESS, LINK_END} link_state_t;

   link_state_t link_state;
   logic link_rst_s1;
   logic link_rst;
   logic req_s1;
   logic req_s2;
   logic req_s3;
   logic [1:0] mode_s1;
   logic [1:0] mode_s2;
   logic link_lp;
   logic link_slow;
   logic [7:0] cyc_cnt;
   logic [7:0] cyc_last;
   logic bus_clk;
   logic ce_active;
   emu_bus_pkg::strobes_t strobes;

   // reset and quasi-static mode levels cross with two flops each
   always_ff @(posedge i_link_clk) begin
      link_rst_s1 <= i_reset;
      link_rst <= link_rst_s1;
      mode_s1 <= {low_power, cfg.cpu_slow};
      mode_s2 <= mode_s1;
   end
   assign link_lp = mode_s2[1];
   assign link_slow = mode_s2[0];

   // halving the link clock gives an exactly even high and low time
   always_ff @(posedge i_link_clk) begin
      if (link_rst) begin
         bus_clk <= 1'b0;
      end else begin
         bus_clk <= ~bus_clk;
      end
   end
   assign o_external_bus_clock_out = bus_clk;

   always_ff @(posedge i_link_clk) begin
      if (link_rst) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
      end else begin
         req_s1 <= req_toggle;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
      end
   end

   assign cyc_last = (link_lp && link_slow) ? 8'(`EMU_SLOW_CYCLES - 1) :
                     8'(`EMU_FAST_CYCLES - 1);
   // in slow power-saving mode the flash sees its enable for one slot only
   assign ce_active = (link_state == LINK_ACCESS) &&
                      (!(link_lp && link_slow) || cyc_cnt < 8'(`EMU_SLOW_CE_CYCLES));

   always_ff @(posedge i_link_clk) begin
      if (link_rst) begin
         link_state <= LINK_IDLE;
         cyc_cnt <= 8'h00;
         done_toggle <= 1'b0;
      end else begin
         unique case (link_state)
            LINK_IDLE: begin
               cyc_cnt <= 8'h00;
               if (req_s2 ^ req_s3) begin
                  link_state <= LINK_ACCESS;
               end
            end
            LINK_ACCESS: begin
               cyc_cnt <= cyc_cnt + 8'h01;
               if (cyc_cnt == cyc_last) begin
                  link_state <= LINK_END;
               end
            end
            LINK_END: begin
               done_toggle <= ~done_toggle;
               link_state <= LINK_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      strobes.cs_n_prog = !(ce_active && !acc_cmd.use_ce1);
      strobes.cs_n_data = !(ce_active && acc_cmd.use_ce1);
      strobes.we_n = !(ce_active && acc_cmd.write);
   end

   always_ff @(posedge i_link_clk) begin
      if (link_rst) begin
         o_program_mem_chip_enable_n <= 1'b1;
         o_data_boot_chip_enable_n <= 1'b1;
         o_write_enable_out_n <= 1'b1;
         o_mem_addr <= '0;
         o_mem_data <= '0;
         o_mem_data_oe <= 1'b0;
      end else begin
         o_program_mem_chip_enable_n <= strobes.cs_n_prog;
         o_data_boot_chip_enable_n <= strobes.cs_n_data;
         o_write_enable_out_n <= strobes.we_n;
         o_mem_addr <= acc_addr;
         o_mem_data <= acc_wdata;
         o_mem_data_oe <= (link_state == LINK_ACCESS) && acc_cmd.write;
      end
   end

   // read data is taken as the enable goes back high; held for the host side
   always_ff @(posedge i_link_clk) begin
      if (link_rst) begin
         link_rdata <= '0;
      end else if (!acc_cmd.write && ((!o_program_mem_chip_enable_n && strobes.cs_n_prog) ||
                   (!o_data_boot_chip_enable_n && strobes.cs_n_data))) begin
         link_rdata <= i_mem_data;
      end
   end

   // the keeper remembers the last level driven, or read through the program enable, on the data bus
   always_ff @(posedge i_link_clk) begin
      if (link_rst) begin
         o_data_hold <= '0;
         o_data_hold_en <= 1'b0;
      end else begin
         if (o_mem_data_oe) begin
            o_data_hold <= o_mem_data;
         end else if (!o_program_mem_chip_enable_n && strobes.cs_n_prog) begin
            o_data_hold <= i_mem_data;
         end
         // judged on the next drive enable, so the keeper never overlaps a write drive
         o_data_hold_en <= !((link_state == LINK_ACCESS) && acc_cmd.write) &&
                           (!bus_clk ||
                            (link_lp && strobes.cs_n_prog));
      end
   end

endmodule : emu_bus_memory_select

// *** hw/emu_bus_pkg.sv ***
// emu_bus_pkg: types shared by the emulation bus memory select block
// assumes: numbers live in emu_bus_map.svh
package emu_bus_pkg;

   typedef enum logic [1:0] {RAM_INTERNAL, RAM_MULTIPIN_BUS, RAM_EMU_BUS} ram_source_t;

   typedef enum logic [1:0] {PINS_BUS0, PINS_BUS1, PINS_BUS2, PINS_PORT} pin_mode_t;

   typedef enum logic [1:0] {CE1_EXT_RAM, CE1_EXT_BOOT, CE1_NONE} ce1_target_t;

   typedef struct packed {
      logic cpu_slow;
      logic async_bus_flag;
      logic power_saving_bus_flag;
      logic two_chip_bus_flag;
      logic test_toggle_bit;
      logic [1:0] multipin_mode_field;
      logic internal_boot_select;
      logic internal_ram_select;
   } config_t;

   typedef struct packed {
      logic use_ce1;
      logic write;
   } access_cmd_t;

   typedef struct packed {
      logic cs_n_prog;
      logic cs_n_data;
      logic we_n;
   } strobes_t;

endpackage : emu_bus_pkg

// *** tb/emu_bus_memory_select_sva.sv ***
// emu_bus_memory_select_sva: port level assertions for the memory select block
// assumes: bound to emu_bus_memory_select, link logic reset from i_reset
`timescale 1ns/10ps
module emu_bus_memory_select_sva #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 32
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire emu_bus_pkg::ram_source_t o_ram_source,
   input wire emu_bus_pkg::pin_mode_t o_pin_mode,
   input wire emu_bus_pkg::ce1_target_t o_ce1_target,
   input wire logic i_link_clk,
   input wire logic o_external_bus_clock_out,
   input wire logic o_program_mem_chip_enable_n,
   input wire logic o_data_boot_chip_enable_n,
   input wire logic o_write_enable_out_n,
   input wire logic o_mem_data_oe,
   input wire logic [DATA_W-1:0] i_mem_data,
   input wire logic o_data_hold_en,
   input wire logic [DATA_W-1:0] o_data_hold
);
   // -------------------------------------------------------------
   // register side
   // -------------------------------------------------------------
   AST_ONE_WAIT: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("waitrequest not one cycle");
   AST_UNMAPPED: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_avs_read && !o_avs_waitrequest && i_avs_address > 8'h14 |-> o_avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_RAM_CE1: assert property (@(posedge i_mclk) disable iff (i_reset)
      (o_ram_source == emu_bus_pkg::RAM_INTERNAL) == (o_ce1_target != emu_bus_pkg::CE1_EXT_RAM))
      else $error("ce1 target disagrees with ram source");
   AST_EMU_PORT: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_ram_source == emu_bus_pkg::RAM_EMU_BUS |-> o_pin_mode == emu_bus_pkg::PINS_PORT)
      else $error("emu bus ram without port mode");
   // -------------------------------------------------------------
   // link side
   // -------------------------------------------------------------
   sequence s_full_access;
      !o_program_mem_chip_enable_n [*4] ##1 o_program_mem_chip_enable_n;
   endsequence
   sequence s_short_access;
      !o_program_mem_chip_enable_n ##1 o_program_mem_chip_enable_n;
   endsequence
   AST_CLK_HIGH: assert property (@(posedge i_link_clk) disable iff (i_reset)
      o_external_bus_clock_out |=> !o_external_bus_clock_out)
      else $error("bus clock high too long");
   AST_CLK_LOW: assert property (@(posedge i_link_clk) disable iff (i_reset)
      !o_external_bus_clock_out && $past(o_external_bus_clock_out) |=> o_external_bus_clock_out)
      else $error("bus clock low too long");
   AST_CE0_LEN: assert property (@(posedge i_link_clk) disable iff (i_reset)
      $fell(o_program_mem_chip_enable_n) |-> s_full_access or s_short_access)
      else $error("program enable length wrong");
   AST_CE_EXCL: assert property (@(posedge i_link_clk) disable iff (i_reset)
      !(!o_program_mem_chip_enable_n && !o_data_boot_chip_enable_n))
      else $error("both chip enables active");
   AST_WE_IN_ACCESS: assert property (@(posedge i_link_clk) disable iff (i_reset)
      !o_write_enable_out_n |-> !o_program_mem_chip_enable_n || !o_data_boot_chip_enable_n)
      else $error("write strobe outside access");
   AST_KEEP_NO_FIGHT: assert property (@(posedge i_link_clk) disable iff (i_reset)
      o_data_hold_en |-> !o_mem_data_oe)
      else $error("keeper on while driving");
   AST_LATCH: assert property (@(posedge i_link_clk) disable iff (i_reset)
      $rose(o_program_mem_chip_enable_n) && $past(o_write_enable_out_n)
      |-> o_data_hold == $past(i_mem_data))
      else $error("read data not latched on enable rise");
endmodule : emu_bus_memory_select_sva

bind emu_bus_memory_select emu_bus_memory_select_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
   .i_mclk(i_mclk), .i_reset(i_reset), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .o_ram_source(o_ram_source),
   .o_pin_mode(o_pin_mode), .o_ce1_target(o_ce1_target), .i_link_clk(i_link_clk),
   .o_external_bus_clock_out(o_external_bus_clock_out),
   .o_program_mem_chip_enable_n(o_program_mem_chip_enable_n),
   .o_data_boot_chip_enable_n(o_data_boot_chip_enable_n),
   .o_write_enable_out_n(o_write_enable_out_n), .o_mem_data_oe(o_mem_data_oe),
   .i_mem_data(i_mem_data), .o_data_hold_en(o_data_hold_en), .o_data_hold(o_data_hold));

// *** tb/emu_bus_memory_select_test.sv ***
// emu_bus_memory_select_test: self-checking bench for the memory select block
// assumes: package, map header and design compiled first, memory model from tb/
`timescale 1ns/10ps
`include "emu_bus_map.svh"
module emu_bus_memory_select_test;
   logic i_mclk = 1'b0;
   logic i_link_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic i_second_test_pin = 1'b0;
   emu_bus_pkg::ram_source_t ram_src;
   emu_bus_pkg::pin_mode_t pin_mode;
   emu_bus_pkg::ce1_target_t ce1_tgt;
   logic bus_clk, ce0_n, ce1_n, we_n, oe, hold_en;
   logic [19:0] maddr;
   logic [31:0] mdata, mem_rd, hold, rdata, avs_q;
   logic wait_req;
   int err_count = 0;
   int checks_done = 0;

   emu_bus_memory_select DUT (.i_mclk(i_mclk), .i_reset(i_reset),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF), .o_avs_readdata(avs_q),
      .o_avs_waitrequest(wait_req), .i_second_test_pin(i_second_test_pin),
      .o_ram_source(ram_src), .o_pin_mode(pin_mode), .o_ce1_target(ce1_tgt),
      .i_link_clk(i_link_clk),
      .o_external_bus_clock_out(bus_clk), .o_program_mem_chip_enable_n(ce0_n),
      .o_data_boot_chip_enable_n(ce1_n), .o_write_enable_out_n(we_n), .o_mem_addr(maddr),
      .o_mem_data(mdata), .o_mem_data_oe(oe), .i_mem_data(mem_rd),
      .o_data_hold_en(hold_en), .o_data_hold(hold));
   emu_mem_model u_mem (.i_clk(i_link_clk), .i_ce0_n(ce0_n), .i_ce1_n(ce1_n), .i_we_n(we_n),
      .i_oe(oe), .i_addr(maddr[3:0]), .i_data(mdata), .o_data(mem_rd));

   initial forever #2.5 i_mclk = ~i_mclk;
   initial begin
      #7;
      forever #40 i_link_clk = ~i_link_clk;
   end

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask : check

   // waitrequest and read data are taken at the answer edge, before the design updates them
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      do begin
         @(posedge i_mclk);
         n++;
      end while (wait_req !== 1'b0 && n < 100);
      q = avs_q;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(posedge i_mclk);
      check(n < 100, 1'b1, "bus answer");
   endtask : xfer

   task automatic access(input logic [2:0] cmd, input logic [19:0] a, input logic [31:0] d,
                         input logic [31:0] exp);
      int n;
      n = 0;
      xfer(1'b1, `EMU_OFS_ADDR, {12'h0, a}, rdata);
      xfer(1'b1, `EMU_OFS_WDATA, d, rdata);
      xfer(1'b1, `EMU_OFS_CMD, {29'h0, cmd}, rdata);
      do begin
         xfer(1'b0, `EMU_OFS_STATUS, 32'h0, rdata);
         n++;
      end while (rdata[`EMU_ST_BUSY_BIT] !== 1'b0 && n < 2000);
      check(rdata[2:1], 2'h1, "done without error");
      if (!cmd[1]) begin
         xfer(1'b0, `EMU_OFS_RDATA, 32'h0, rdata);
         check(rdata, exp, "read data");
      end
   endtask : access

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_decode();
      logic [3:0] c;
      logic [1:0] er, ec;
      for (int i = 0; i < 16; i++) begin
         c = i[3:0];
         er = c[0] ? 2'h0 : (c[3:2] == 2'h3 ? 2'h2 : 2'h1);
         ec = !c[0] ? 2'h0 : (c[1] ? 2'h2 : 2'h1);
         xfer(1'b1, `EMU_OFS_CONFIG, {28'h0, c}, rdata);
         xfer(1'b0, `EMU_OFS_STATUS, 32'h0, rdata);
         check({30'h0, ram_src}, {30'h0, er}, "ram source");
         check({30'h0, pin_mode}, {30'h0, c[3:2]}, "pin mode");
         check({30'h0, ce1_tgt}, {30'h0, ec}, "ce1 target");
         check({rdata[13:12], rdata[9:8], rdata[5:4]}, {ec, c[3:2], er}, "status");
      end
      $display("test decode done");
   endtask : t_decode

   task automatic t_toggle();
      xfer(1'b1, `EMU_OFS_CONFIG, 32'h14, rdata);
      check({30'h0, pin_mode}, 32'h1, "toggle, pin low");
      i_second_test_pin <= 1'b1;
      repeat (4) @(negedge i_mclk);
      check({30'h0, pin_mode}, 32'h3, "toggle, pin high");
      @(posedge i_mclk);
      xfer(1'b1, `EMU_OFS_CONFIG, 32'h04, rdata);
      check({30'h0, pin_mode}, 32'h1, "pin high, no toggle");
      i_second_test_pin <= 1'b0;
      $display("test toggle done");
   endtask : t_toggle

   task automatic t_access();
      xfer(1'b1, `EMU_OFS_CONFIG, 32'hA0, rdata);
      access(3'h3, 20'h5, 32'hA5A50F0F, 32'h0);
      access(3'h7, 20'h6, 32'h3C3C1234, 32'h0);
      access(3'h1, 20'h5, 32'h0, 32'hA5A50F0F);
      access(3'h5, 20'h6, 32'h0, 32'h3C3C1234);
      $display("test access done");
   endtask : t_access

   task automatic t_lowpower();
      logic [31:0] cfg [4] = '{32'h1C0, 32'hC0, 32'hE0, 32'h140};
      logic lp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      // a write with the keeper active must never leave it fighting the drive
      xfer(1'b1, `EMU_OFS_CONFIG, 32'hC0, rdata);
      access(3'h3, 20'h9, 32'h5A000009, 32'h0);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, `EMU_OFS_CONFIG, cfg[i], rdata);
         access(3'h1, 20'h9, 32'h0, 32'h5A000009);
         xfer(1'b0, `EMU_OFS_STATUS, 32'h0, rdata);
         check(rdata[`EMU_ST_LOWPWR_BIT], lp[i], "low power flag");
      end
      $display("test low power done");
   endtask : t_lowpower

   task automatic t_refuse();
      logic [31:0] cfg [2] = '{32'h00, 32'h23};
      for (int i = 0; i < 2; i++) begin
         xfer(1'b1, `EMU_OFS_CONFIG, cfg[i], rdata);
         // an accepted access clears err, so each refusal must set it afresh
         access(3'h1, 20'h9, 32'h0, 32'h5A000009);
         xfer(1'b1, `EMU_OFS_CMD, 32'h5, rdata);
         xfer(1'b0, `EMU_OFS_STATUS, 32'h0, rdata);
         check(rdata[`EMU_ST_ERR_BIT], 1'b1, "ce1 refused");
      end
      xfer(1'b0, 8'h20, 32'h0, rdata);
      check(rdata, 32'h0, "unmapped read");
      $display("test refuse done");
   endtask : t_refuse

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   // reset spans link edges too, since the link logic takes it through two flops
   initial begin
      repeat (6) @(posedge i_link_clk);
      @(posedge i_mclk);
      i_reset <= 1'b0;
      repeat (6) @(posedge i_link_clk);
      @(posedge i_mclk);
      t_decode();
      t_toggle();
      t_access();
      t_lowpower();
      t_refuse();
      summarize();
   end

   initial begin
      repeat (60000) @(posedge i_mclk);
      err_count++;
      summarize();
   end
endmodule : emu_bus_memory_select_test

// *** tb/emu_mem_model.sv ***
// emu_mem_model: behavioural external memory, one 16 word bank per chip enable
// assumes: enables and strobe launched on the link clock, data read while enable low
`timescale 1ns/10ps
module emu_mem_model (
   input wire logic i_clk,
   input wire logic i_ce0_n,
   input wire logic i_ce1_n,
   input wire logic i_we_n,
   input wire logic i_oe,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_data,
   output logic [31:0] o_data
);
   logic [31:0] mem [0:31];
   logic [31:0] last = 32'h0;
   logic sel;
   assign sel = !i_ce0_n || !i_ce1_n;
   // released bus shows the inverse of the last value, so a stale capture cannot pass
   assign o_data = (sel && i_we_n) ? mem[{i_ce0_n, i_addr}] : ~last;
   always @(posedge i_clk) begin
      last <= o_data;
      if (sel && !i_we_n && i_oe) mem[{i_ce0_n, i_addr}] <= i_data;
   end
   initial for (int k = 0; k < 32; k++) mem[k] = {27'h2D00000, k[4:0]};
endmodule : emu_mem_model
